//--- rtl/tots_params.svh
`ifndef TOTS_PARAMS_SVH
`define TOTS_PARAMS_SVH
`define TOTS_CMD_LIMIT     8'h62
`define TOTS_CMD_RESP      8'h63
`define TOTS_CMD_OFFDLY    8'h64
`define TOTS_CMD_FALL      8'h65
`define TOTS_RST_LIMIT     16'hf8c8
`define TOTS_RST_RESP      8'h80
`define TOTS_RST_OFFDLY    16'hf800
`define TOTS_RST_FALL      16'hf004
`define TOTS_CLK_NS        4
`define TOTS_TICK_US       250
`define TOTS_TICK_CYC      (`TOTS_TICK_US * 1000 / `TOTS_CLK_NS)
`define TOTS_OFF_LAT_US    50
`define TOTS_LIMIT_MAX_Q   18'h001fc
`define TOTS_OFFDLY_MAX_Q  18'h001fe
`define TOTS_FALL_MAX_Q    18'h0007f
`define TOTS_RAMP_MIN_Q    18'h00002
`define TOTS_Q_PER_MS      22'h000004
`define TOTS_THR_NUM       22'h000011
`define TOTS_THR_DEN       22'h000014
`define TOTS_ACT_HI        7
`define TOTS_ACT_LO        6
`define TOTS_RTY_HI        5
`define TOTS_RTY_LO        3
`define TOTS_DLY_HI        2
`define TOTS_DLY_LO        0
`define TOTS_ACT_IGNORE    2'h0
`define TOTS_ACT_DELAYED   2'h1
`define TOTS_ACT_NOW       2'h2
`define TOTS_ACT_BAD       2'h3
`define TOTS_RTY_LATCH     3'h0
`define TOTS_RTY_FOREVER   3'h7
`endif

//--- rtl/tots_pkg.sv
package tots_pkg;
  typedef enum logic [2:0] {
    ST_OFF    = 3'h0,
    ST_ONDLY  = 3'h1,
    ST_RISE   = 3'h3,
    ST_ON     = 3'h2,
    ST_OFFDLY = 3'h6,
    ST_FALL   = 3'h7,
    ST_HICCUP = 3'h5,
    ST_LATCH  = 3'h4
  } tots_state_t;

  typedef struct packed {
    logic        ok;
    logic [17:0] q;
  } tots_dec_t;

  // linear word to quarter-millisecond count, exact or not ok
  function automatic tots_dec_t lin_decode(input logic [15:0] w);
    logic signed [6:0] sh;
    logic [4:0]        n;
    logic [31:0]       wide;
    tots_dec_t         r;
    sh = 7'(signed'(w[15:11])) + 7'sd2;
    wide = {21'h0, w[10:0]};
    r.ok = ~w[10];
    r.q = 18'h0;
    if (sh > 7'sd8) begin
      r.ok = r.ok & (w[10:0] == 11'h0);
    end else if (sh >= 7'sd0) begin
      wide = wide << sh[3:0];
      r.q = wide[17:0];
    end else begin
      n = 5'(-sh);
      r.ok = r.ok & ((wide & ((32'h1 << n) - 32'h1)) == 32'h0);
      wide = wide >> n;
      r.q = wide[17:0];
    end
    return r;
  endfunction
endpackage

//--- rtl/tots_ramp_if.sv
`timescale 1ns/1ns
interface tots_ramp_if;
  logic        start;
  logic        down;
  logic [15:0] target;
  logic [31:0] span;
  logic [15:0] level;
  logic        done;
  modport ctrl (output start, output down, output target, output span, input level, input done);
  modport gen  (input start, input down, input target, input span, output level, output done);
endinterface

//--- rtl/tots_tick.sv
`timescale 1ns/1ns
`include "tots_params.svh"
module tots_tick #(
  parameter int unsigned CYCLES = `TOTS_TICK_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  input  wire logic i_clr,
  output logic      o_tick
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        next_tick;

  always_comb begin
    next_cnt = cnt + 32'h1;
    next_tick = 1'b0;
    if (i_clr) begin
      next_cnt = 32'h0;
    end else if (cnt >= 32'(CYCLES - 1)) begin
      next_cnt = 32'h0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt <= 32'h0;
      o_tick <= 1'b0;
    end else if (i_ce) begin
      cnt <= next_cnt;
      o_tick <= next_tick;
    end
  end
endmodule

//--- rtl/tots_ramp.sv
`timescale 1ns/1ns
module tots_ramp (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  tots_ramp_if.gen  rif
);
  logic        active;
  logic        next_active;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic [31:0] acc;
  logic [31:0] next_acc;
  logic [15:0] level;
  logic [15:0] next_level;
  logic        done;
  logic        next_done;
  logic [31:0] sum;

  assign rif.level = level;
  assign rif.done = done;

  // error accumulator spreads steps so the ramp lasts exactly span cycles
  always_comb begin
    next_active = active;
    next_cnt = cnt;
    next_acc = acc;
    next_level = level;
    next_done = 1'b0;
    sum = acc + {16'h0, rif.target};
    if (rif.start) begin
      next_active = 1'b1;
      next_cnt = 32'h0;
      next_acc = 32'h0;
      next_level = rif.down ? rif.target : 16'h0;
    end else if (active) begin
      next_cnt = cnt + 32'h1;
      next_acc = sum;
      if (sum >= rif.span) begin
        next_acc = sum - rif.span;
        next_level = rif.down ? level - 16'h1 : level + 16'h1;
      end
      if (next_cnt >= rif.span) begin
        next_active = 1'b0;
        next_done = 1'b1;
        next_level = rif.down ? 16'h0 : rif.target;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      active <= 1'b0;
      cnt <= 32'h0;
      acc <= 32'h0;
      level <= 16'h0;
      done <= 1'b0;
    end else if (i_ce) begin
      active <= next_active;
      cnt <= next_cnt;
      acc <= next_acc;
      level <= next_level;
      done <= next_done;
    end
  end
endmodule

//--- rtl/tots_top.sv
`timescale 1ns/1ns
`include "tots_params.svh"
module tots_top #(
  parameter int unsigned TICK_CYCLES = `TOTS_TICK_CYC
) (
  input  wire logic        I_REF_CLK,
  input  wire logic        I_SYS_RST,
  input  wire logic        I_CE,
  input  wire logic        I_CMD_VALID,
  input  wire logic        I_CMD_WRITE,
  input  wire logic        I_CMD_WORD,
  input  wire logic [7:0]  I_CMD_CODE,
  input  wire logic [15:0] I_CMD_WDATA,
  input  wire logic        I_CLEAR_FAULTS,
  input  wire logic        I_RUN,
  input  wire logic [15:0] I_TON_DELAY,
  input  wire logic [15:0] I_RISE_TIME,
  input  wire logic [15:0] I_VOUT_TARGET,
  input  wire logic [15:0] I_VOUT_SENSE,
  input  wire logic        I_UV_FAULT,
  input  wire logic        I_UV_IGNORE,
  output logic             O_CMD_ACK,
  output logic [15:0]      O_CMD_RDATA,
  output logic             O_POWER_EN,
  output logic [15:0]      O_DAC_REF,
  output logic             O_UV_DETECT_EN,
  output logic             O_OFF,
  output logic             O_NOTA,
  output logic             O_VOUT_SUMMARY,
  output logic             O_TONMAX_FAULT,
  output logic             O_CML_INVALID,
  output logic             O_ALERT
);
  // ****************************************
  // settings registers and command port
  // ****************************************
  logic [15:0]         limit;
  logic [15:0]         next_limit;
  logic [7:0]          resp;
  logic [7:0]          next_resp;
  logic [15:0]         offdly;
  logic [15:0]         next_offdly;
  logic [15:0]         fall;
  logic [15:0]         next_fall;
  logic                next_ack;
  logic [15:0]         next_rdata;
  logic                cmd_bad;
  tots_pkg::tots_dec_t d_wr;

  assign d_wr = tots_pkg::lin_decode(I_CMD_WDATA);

  always_comb begin
    next_limit = limit;
    next_resp = resp;
    next_offdly = offdly;
    next_fall = fall;
    next_ack = 1'b0;
    next_rdata = O_CMD_RDATA;
    cmd_bad = 1'b0;
    if (I_CMD_VALID) begin
      case (I_CMD_CODE)
        `TOTS_CMD_LIMIT: begin
          next_ack = 1'b1;
          next_rdata = limit;
          if (~I_CMD_WORD) begin
            cmd_bad = 1'b1;
          end else if (I_CMD_WRITE) begin
            if (d_wr.ok && d_wr.q <= `TOTS_LIMIT_MAX_Q && ~d_wr.q[0]) begin
              next_limit = I_CMD_WDATA;
            end else begin
              cmd_bad = 1'b1;
            end
          end
        end
        `TOTS_CMD_RESP: begin
          next_ack = 1'b1;
          next_rdata = {8'h0, resp};
          if (I_CMD_WORD) begin
            cmd_bad = 1'b1;
          end else if (I_CMD_WRITE) begin
            if (I_CMD_WDATA[`TOTS_ACT_HI:`TOTS_ACT_LO] == `TOTS_ACT_BAD) begin
              cmd_bad = 1'b1;
            end else begin
              next_resp = I_CMD_WDATA[7:0];
            end
          end
        end
        `TOTS_CMD_OFFDLY: begin
          next_ack = 1'b1;
          next_rdata = offdly;
          if (~I_CMD_WORD) begin
            cmd_bad = 1'b1;
          end else if (I_CMD_WRITE) begin
            if (d_wr.ok && d_wr.q <= `TOTS_OFFDLY_MAX_Q && ~d_wr.q[0]) begin
              next_offdly = I_CMD_WDATA;
            end else begin
              cmd_bad = 1'b1;
            end
          end
        end
        `TOTS_CMD_FALL: begin
          next_ack = 1'b1;
          next_rdata = fall;
          if (~I_CMD_WORD) begin
            cmd_bad = 1'b1;
          end else if (I_CMD_WRITE) begin
            if (d_wr.ok && d_wr.q <= `TOTS_FALL_MAX_Q) begin
              next_fall = I_CMD_WDATA;
            end else begin
              cmd_bad = 1'b1;
            end
          end
        end
        default: begin
          next_ack = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      limit <= `TOTS_RST_LIMIT;
      resp <= `TOTS_RST_RESP;
      offdly <= `TOTS_RST_OFFDLY;
      fall <= `TOTS_RST_FALL;
      O_CMD_ACK <= 1'b0;
      O_CMD_RDATA <= 16'h0;
    end else if (I_CE) begin
      limit <= next_limit;
      resp <= next_resp;
      offdly <= next_offdly;
      fall <= next_fall;
      O_CMD_ACK <= next_ack;
      O_CMD_RDATA <= next_rdata;
    end
  end

  // ****************************************
  // derived timings in quarter milliseconds
  // ****************************************
  tots_pkg::tots_dec_t d_lim;
  tots_pkg::tots_dec_t d_ton;
  tots_pkg::tots_dec_t d_rise;
  tots_pkg::tots_dec_t d_off;
  tots_pkg::tots_dec_t d_fall;
  logic [17:0]         rise_q;
  logic [17:0]         fall_q;
  logic [2:0]          dly_code;
  logic [2:0]          dly_mult;
  logic [21:0]         sd_q;
  logic [21:0]         hic_q;
  logic [1:0]          act;
  logic [2:0]          rty;
  logic                reached;

  assign d_lim = tots_pkg::lin_decode(limit);
  assign d_ton = tots_pkg::lin_decode(I_TON_DELAY);
  assign d_rise = tots_pkg::lin_decode(I_RISE_TIME);
  assign d_off = tots_pkg::lin_decode(offdly);
  assign d_fall = tots_pkg::lin_decode(fall);
  assign rise_q = (d_rise.q < `TOTS_RAMP_MIN_Q) ? `TOTS_RAMP_MIN_Q : d_rise.q;
  assign fall_q = (d_fall.q < `TOTS_RAMP_MIN_Q) ? `TOTS_RAMP_MIN_Q : d_fall.q;
  assign act = resp[`TOTS_ACT_HI:`TOTS_ACT_LO];
  assign rty = resp[`TOTS_RTY_HI:`TOTS_RTY_LO];
  assign dly_code = resp[`TOTS_DLY_HI:`TOTS_DLY_LO];
  assign dly_mult = (dly_code == 3'h0) ? 3'h1 : dly_code;
  assign sd_q = 22'(dly_mult) * `TOTS_Q_PER_MS + 22'h1;
  assign hic_q = 22'(22'(dly_mult) * {4'h0, rise_q});
  assign reached = ({6'h0, I_VOUT_SENSE} * `TOTS_THR_DEN) >= ({6'h0, I_VOUT_TARGET} * `TOTS_THR_NUM);

  // ****************************************
  // sequencer
  // ****************************************
  tots_pkg::tots_state_t state;
  tots_pkg::tots_state_t next_state;
  logic [21:0]           cnt;
  logic [21:0]           next_cnt;
  logic                  tm_on;
  logic                  next_tm_on;
  logic [17:0]           tm_cnt;
  logic [17:0]           next_tm_cnt;
  logic                  fd_on;
  logic                  next_fd_on;
  logic [21:0]           fd_cnt;
  logic [21:0]           next_fd_cnt;
  logic [2:0]            rty_cnt;
  logic [2:0]            next_rty_cnt;
  logic                  rstart;
  logic                  next_rstart;
  logic                  rdown;
  logic                  next_rdown;
  logic [17:0]           rspan_q;
  logic [17:0]           next_rspan_q;
  logic                  next_power;
  logic                  next_uv_en;
  logic                  next_nota;
  logic                  next_vout;
  logic                  next_tonmax;
  logic                  next_cml;
  logic                  shutdown;
  logic                  fault_set;
  logic                  tick;
  tots_ramp_if           rif ();

  assign rif.start = rstart;
  assign rif.down = rdown;
  assign rif.target = I_VOUT_TARGET;
  // span in cycles, independent of target
  assign rif.span = 32'(rspan_q) * 32'(TICK_CYCLES);

  tots_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .i_clk  (I_REF_CLK),
    .i_rst  (I_SYS_RST),
    .i_ce   (I_CE),
    .i_clr  (next_state != state),
    .o_tick (tick)
  );

  tots_ramp u_ramp (
    .i_clk (I_REF_CLK),
    .i_rst (I_SYS_RST),
    .i_ce  (I_CE),
    .rif   (rif)
  );

  always_comb begin
    next_state = state;
    next_cnt = tick ? cnt + 22'h1 : cnt;
    next_tm_on = tm_on;
    next_tm_cnt = (tick && tm_on) ? tm_cnt + 18'h1 : tm_cnt;
    next_fd_on = fd_on;
    next_fd_cnt = (tick && fd_on) ? fd_cnt + 22'h1 : fd_cnt;
    next_rty_cnt = rty_cnt;
    next_rstart = 1'b0;
    next_rdown = rdown;
    next_rspan_q = rspan_q;
    next_power = O_POWER_EN;
    next_uv_en = O_UV_DETECT_EN;
    shutdown = 1'b0;
    fault_set = 1'b0;
    case (state)
      tots_pkg::ST_OFF: begin
        if (I_RUN) begin
          next_state = tots_pkg::ST_ONDLY;
          next_cnt = 22'h0;
        end
      end
      tots_pkg::ST_ONDLY: begin
        if (cnt >= {4'h0, d_ton.q}) begin
          next_state = tots_pkg::ST_RISE;
          next_rstart = 1'b1;
          next_rdown = 1'b0;
          next_rspan_q = rise_q;
          next_power = 1'b1;
          next_tm_on = 1'b1;
          next_tm_cnt = 18'h0;
        end
      end
      tots_pkg::ST_RISE: begin
        if (rif.done) begin
          next_state = tots_pkg::ST_ON;
          next_uv_en = 1'b1;
        end
      end
      tots_pkg::ST_OFFDLY: begin
        if (cnt >= {4'h0, d_off.q}) begin
          next_state = tots_pkg::ST_FALL;
          next_rstart = 1'b1;
          next_rdown = 1'b1;
          next_rspan_q = fall_q;
        end
      end
      tots_pkg::ST_FALL: begin
        if (rif.done) begin
          next_state = tots_pkg::ST_OFF;
          next_power = 1'b0;
        end
      end
      tots_pkg::ST_HICCUP: begin
        if (cnt >= hic_q) begin
          next_state = tots_pkg::ST_ONDLY;
          next_cnt = 22'h0;
        end
      end
      default: begin
        next_state = state;
      end
    endcase
    if (tm_on) begin
      if (reached) begin
        next_tm_on = 1'b0;
        next_fd_on = 1'b0;
        next_rty_cnt = 3'h0;
      end else if (O_UV_DETECT_EN && I_UV_FAULT && ~I_UV_IGNORE) begin
        next_tm_on = 1'b0;
      end else if (d_lim.q != 18'h0 && tm_cnt >= d_lim.q) begin
        next_tm_on = 1'b0;
        fault_set = 1'b1;
        if (act == `TOTS_ACT_DELAYED) begin
          next_fd_on = 1'b1;
          next_fd_cnt = 22'h0;
        end else if (act == `TOTS_ACT_NOW) begin
          shutdown = 1'b1;
        end
      end
    end
    if (fd_on && fd_cnt >= sd_q) begin
      next_fd_on = 1'b0;
      shutdown = ~reached;
    end
    if (shutdown) begin
      next_power = 1'b0;
      next_uv_en = 1'b0;
      next_fd_on = 1'b0;
      next_cnt = 22'h0;
      if (rty == `TOTS_RTY_LATCH || (rty != `TOTS_RTY_FOREVER && rty_cnt >= rty)) begin
        next_state = tots_pkg::ST_LATCH;
      end else begin
        next_state = tots_pkg::ST_HICCUP;
        next_rty_cnt = (rty == `TOTS_RTY_FOREVER) ? rty_cnt : rty_cnt + 3'h1;
      end
    end
    if (~I_RUN) begin
      next_rty_cnt = 3'h0;
      next_tm_on = 1'b0;
      next_fd_on = 1'b0;
      next_uv_en = 1'b0;
      if ((state == tots_pkg::ST_RISE || state == tots_pkg::ST_ON) && ~shutdown) begin
        next_state = tots_pkg::ST_OFFDLY;
        next_cnt = 22'h0;
      end else if (state != tots_pkg::ST_OFFDLY && state != tots_pkg::ST_FALL) begin
        next_state = tots_pkg::ST_OFF;
        next_power = 1'b0;
      end
    end
    next_nota = (O_NOTA & ~I_CLEAR_FAULTS) | fault_set;
    next_vout = (O_VOUT_SUMMARY & ~I_CLEAR_FAULTS) | fault_set;
    next_tonmax = (O_TONMAX_FAULT & ~I_CLEAR_FAULTS) | fault_set;
    next_cml = (O_CML_INVALID & ~I_CLEAR_FAULTS) | cmd_bad;
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      state <= tots_pkg::ST_OFF;
      cnt <= 22'h0;
      tm_on <= 1'b0;
      tm_cnt <= 18'h0;
      fd_on <= 1'b0;
      fd_cnt <= 22'h0;
      rty_cnt <= 3'h0;
      rstart <= 1'b0;
      rdown <= 1'b0;
      rspan_q <= `TOTS_RAMP_MIN_Q;
      O_POWER_EN <= 1'b0;
      O_DAC_REF <= 16'h0;
      O_UV_DETECT_EN <= 1'b0;
      O_OFF <= 1'b1;
      O_NOTA <= 1'b0;
      O_VOUT_SUMMARY <= 1'b0;
      O_TONMAX_FAULT <= 1'b0;
      O_CML_INVALID <= 1'b0;
      O_ALERT <= 1'b0;
    end else if (I_CE) begin
      state <= next_state;
      cnt <= next_cnt;
      tm_on <= next_tm_on;
      tm_cnt <= next_tm_cnt;
      fd_on <= next_fd_on;
      fd_cnt <= next_fd_cnt;
      rty_cnt <= next_rty_cnt;
      rstart <= next_rstart;
      rdown <= next_rdown;
      rspan_q <= next_rspan_q;
      O_POWER_EN <= next_power;
      O_DAC_REF <= next_power ? rif.level : 16'h0;
      O_UV_DETECT_EN <= next_uv_en;
      O_OFF <= ~next_power;
      O_NOTA <= next_nota;
      O_VOUT_SUMMARY <= next_vout;
      O_TONMAX_FAULT <= next_tonmax;
      O_CML_INVALID <= next_cml;
      O_ALERT <= next_nota | next_cml;
    end
  end
endmodule

//--- verification/tots_assertions.sv
`timescale 1ns/1ns
module tots_checker (
  input  wire logic        I_REF_CLK,
  input  wire logic        I_SYS_RST,
  input  wire logic        I_CMD_VALID,
  input  wire logic        I_CMD_WRITE,
  input  wire logic        I_CMD_WORD,
  input  wire logic [7:0]  I_CMD_CODE,
  input  wire logic [15:0] I_CMD_WDATA,
  input  wire logic        I_RUN,
  input  wire logic        O_CMD_ACK,
  input  wire logic        O_POWER_EN,
  input  wire logic [15:0] O_DAC_REF,
  input  wire logic        O_UV_DETECT_EN,
  input  wire logic        O_NOTA,
  input  wire logic        O_VOUT_SUMMARY,
  input  wire logic        O_TONMAX_FAULT,
  input  wire logic        O_CML_INVALID,
  input  wire logic        O_ALERT
);
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_SYS_RST);
  sequence resp_write;
    I_CMD_VALID && I_CMD_WRITE && I_CMD_CODE == 8'h63;
  endsequence
  sequence stays_off;
    !O_POWER_EN [*3];
  endsequence
  a_alert_on_fault: assert property ($rose(O_NOTA) |-> ##[0:1] O_ALERT)
    else $error("alert missing after fault");
  a_fault_flags_together: assert property ($rose(O_TONMAX_FAULT) |-> O_NOTA && O_VOUT_SUMMARY)
    else $error("status flags not set together");
  a_ack_has_cause: assert property (O_CMD_ACK |-> $past(I_CMD_VALID) && ($past(I_CMD_CODE) inside {[8'h62:8'h65]}))
    else $error("ack without known command");
  a_resp_word_refused: assert property ((resp_write ##0 I_CMD_WORD) |=> O_CML_INVALID)
    else $error("word access on byte setting not flagged");
  a_resp_action_bad: assert property ((resp_write ##0 (!I_CMD_WORD && I_CMD_WDATA[7:6] == 2'h3)) |=> O_CML_INVALID)
    else $error("bad action code not flagged");
  a_dac_zero_off: assert property (stays_off |-> O_DAC_REF == 16'h0)
    else $error("reference not zero while off");
  a_uv_after_rise: assert property ($rose(O_POWER_EN) |-> !O_UV_DETECT_EN [*8])
    else $error("undervoltage detect enabled during rise");
  a_stop_holds_power: assert property (($fell(I_RUN) && O_POWER_EN && O_UV_DETECT_EN) |=> O_POWER_EN [*4])
    else $error("power dropped without off delay");
endmodule

//--- verification/tots_plant.sv
`timescale 1ns/1ns
module tots_plant (
  input  wire logic        i_power_en,
  input  wire logic [15:0] i_dac_ref,
  input  wire logic        i_uv_en,
  input  wire logic [15:0] i_target,
  input  wire logic        i_slow,
  output logic      [15:0] o_sense,
  output logic             o_uv_fault
);
  // output follows reference, half of it when slow
  assign o_sense    = (i_power_en === 1'b1) ? (i_slow ? {1'b0, i_dac_ref[15:1]} : i_dac_ref) : 16'h0;
  assign o_uv_fault = (i_uv_en === 1'b1) && (20 * o_sense < 17 * i_target);
endmodule

//--- verification/turn_on_off_timing_supervisor_tb.sv
`timescale 1ns/1ns
`include "tots_params.svh"
module turn_on_off_timing_supervisor_tb;
  localparam int TICK = 8;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        valid = 1'b0;
  logic        wr = 1'b0;
  logic        word = 1'b0;
  logic [7:0]  code = 8'h0;
  logic [15:0] wdata = 16'h0;
  logic        clr = 1'b0;
  logic        run = 1'b0;
  logic [15:0] rise = 16'hf004;
  logic        slow = 1'b0;
  logic        uv_ign = 1'b1;
  logic [15:0] sense, rdata, dac, r, d, old, m;
  logic        uv_f, ack, pwr, uv_en, off, nota, vsum, tmo, cml, alert, ok, wd, prev;
  logic [7:0]  c;
  logic [25:0] tbl [7] = '{{8'h62, 2'h3, 16'hf8fe}, {8'h62, 2'h2, 16'hf900}, {8'h62, 2'h2, 16'hf001},
                           {8'h64, 2'h3, 16'hf8ff}, {8'h64, 2'h2, 16'hf900}, {8'h63, 2'h2, 16'h0080},
                           {8'h63, 2'h0, 16'h00c0}};
  int          failures = 0;
  int          checks = 0;
  int          seed = 79;
  int          cyc = 0;
  int          n, rises, expc;

  tots_top #(.TICK_CYCLES(TICK)) i_dut (
    .I_REF_CLK(clk), .I_SYS_RST(rst), .I_CE(1'b1), .I_CMD_VALID(valid), .I_CMD_WRITE(wr),
    .I_CMD_WORD(word), .I_CMD_CODE(code), .I_CMD_WDATA(wdata), .I_CLEAR_FAULTS(clr), .I_RUN(run),
    .I_TON_DELAY(16'h0), .I_RISE_TIME(rise), .I_VOUT_TARGET(16'h000c), .I_VOUT_SENSE(sense),
    .I_UV_FAULT(uv_f), .I_UV_IGNORE(uv_ign), .O_CMD_ACK(ack), .O_CMD_RDATA(rdata), .O_POWER_EN(pwr),
    .O_DAC_REF(dac), .O_UV_DETECT_EN(uv_en), .O_OFF(off), .O_NOTA(nota), .O_VOUT_SUMMARY(vsum),
    .O_TONMAX_FAULT(tmo), .O_CML_INVALID(cml), .O_ALERT(alert)
  );
  tots_plant i_plant (
    .i_power_en(pwr), .i_dac_ref(dac), .i_uv_en(uv_en), .i_target(16'h000c), .i_slow(slow),
    .o_sense(sense), .o_uv_fault(uv_f)
  );

  // ****************
  // helpers
  // ****************
  initial begin
    forever #2 clk = ~clk;
  end
  function automatic int cycles_of(input logic [15:0] w);
    return (w[15:11] == 5'h1f ? 2 * int'(w[10:0]) : int'(w[10:0])) * TICK;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic w, input logic sz, input logic [7:0] cc, input logic [15:0] dd);
    @(negedge clk);
    valid = 1'b1;
    wr = w;
    word = sz;
    code = cc;
    wdata = dd;
    @(negedge clk);
    valid = 1'b0;
    r = rdata;
    chk(ack, 1'b1);
  endtask
  task automatic clear_f();
    @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
  endtask
  task automatic wait_on(input logic on_tmo, input logic v);
    n = 0;
    while ((on_tmo ? tmo : pwr) !== v && n < 2000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      test_done();
    end
  end

  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    chk(off, 1'b1);
    cmd(1'b0, 1'b1, `TOTS_CMD_LIMIT, 16'h0);
    chk(r, `TOTS_RST_LIMIT);
    cmd(1'b0, 1'b0, `TOTS_CMD_RESP, 16'h0);
    chk(r[7:0], `TOTS_RST_RESP);
    cmd(1'b0, 1'b1, `TOTS_CMD_OFFDLY, 16'h0);
    chk(r, `TOTS_RST_OFFDLY);
    cmd(1'b0, 1'b1, `TOTS_CMD_FALL, 16'h0);
    chk(r, `TOTS_RST_FALL);
    $display("register reset test done");
    for (int i = 0; i < 7; i++) begin
      {c, wd, ok, d} = tbl[i];
      m = (c == 8'h63) ? 16'h00ff : 16'hffff;
      clear_f();
      cmd(1'b0, c != 8'h63, c, 16'h0);
      old = r;
      cmd(1'b1, wd, c, d);
      chk(cml, !ok);
      cmd(1'b0, c != 8'h63, c, 16'h0);
      chk(r & m, (ok ? d : old) & m);
    end
    clear_f();
    chk(alert, 1'b0);
    for (int i = 0; i < 8; i++) begin
      d = 16'($random(seed));
      if (d[7:6] == 2'h3)
        d[7] = 1'b0;
      cmd(1'b1, 1'b0, `TOTS_CMD_RESP, d);
      cmd(1'b0, 1'b0, `TOTS_CMD_RESP, 16'h0);
      chk(r[7:0], d[7:0]);
    end
    $display("command test done");
    cmd(1'b1, 1'b1, `TOTS_CMD_OFFDLY, 16'hf802);
    @(negedge clk);
    run = 1'b1;
    wait_on(1'b0, 1'b1);
    chk({pwr, off}, 2'h2);
    repeat (40) @(negedge clk);
    chk(uv_en, 1'b1);
    chk(dac, 16'h000c);
    run = 1'b0;
    expc = cycles_of(16'hf802) + cycles_of(`TOTS_RST_FALL);
    wait_on(1'b0, 1'b0);
    chk(n >= expc && n <= expc + 8, 1'b1);
    chk(dac, 16'h0);
    $display("turn-off test done");
    cmd(1'b1, 1'b1, `TOTS_CMD_LIMIT, 16'hf801);
    cmd(1'b1, 1'b0, `TOTS_CMD_RESP, 16'h0080);
    slow = 1'b1;
    @(negedge clk);
    run = 1'b1;
    wait_on(1'b1, 1'b1);
    chk(n >= cycles_of(16'hf801) && n <= cycles_of(16'hf801) + 8, 1'b1);
    chk({nota, vsum, alert}, 3'h7);
    repeat (2) @(negedge clk);
    chk(pwr, 1'b0);
    repeat (200) @(negedge clk);
    chk(pwr, 1'b0);
    run = 1'b0;
    $display("latch-off test done");
    cmd(1'b1, 1'b0, `TOTS_CMD_RESP, 16'h0049);
    for (int k = 0; k < 2; k++) begin
      clear_f();
      run = 1'b1;
      wait_on(1'b1, 1'b1);
      repeat (30) @(negedge clk);
      chk(pwr, 1'b1);
      rises = 0;
      repeat (600) begin
        prev = pwr;
        @(negedge clk);
        if (!prev && pwr)
          rises++;
      end
      chk(rises, 1);
      run = 1'b0;
    end
    $display("retry test done");
    clear_f();
    cmd(1'b1, 1'b1, `TOTS_CMD_LIMIT, 16'h0000);
    run = 1'b1;
    repeat (300) @(negedge clk);
    chk({tmo, pwr}, 2'h1);
    run = 1'b0;
    cmd(1'b1, 1'b1, `TOTS_CMD_LIMIT, 16'hf804);
    rise = 16'hf002;
    uv_ign = 1'b0;
    repeat (60) @(negedge clk);
    run = 1'b1;
    repeat (150) @(negedge clk);
    chk(tmo, 1'b0);
    run = 1'b0;
    $display("supervision test done");
    test_done();
  end
endmodule

bind tots_top tots_checker i_chk (
  .I_REF_CLK(I_REF_CLK), .I_SYS_RST(I_SYS_RST), .I_CMD_VALID(I_CMD_VALID), .I_CMD_WRITE(I_CMD_WRITE),
  .I_CMD_WORD(I_CMD_WORD), .I_CMD_CODE(I_CMD_CODE), .I_CMD_WDATA(I_CMD_WDATA), .I_RUN(I_RUN),
  .O_CMD_ACK(O_CMD_ACK), .O_POWER_EN(O_POWER_EN), .O_DAC_REF(O_DAC_REF), .O_UV_DETECT_EN(O_UV_DETECT_EN),
  .O_NOTA(O_NOTA), .O_VOUT_SUMMARY(O_VOUT_SUMMARY), .O_TONMAX_FAULT(O_TONMAX_FAULT),
  .O_CML_INVALID(O_CML_INVALID), .O_ALERT(O_ALERT)
);
